/* hdl/program_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - a 10-bit fetch address counter holds the address of the next instruction to fetch.
// - any fetch that is not a branch after a page load, a taken branch, call or return advances the counter by one.
// - reset clears the fetch address counter to zero.
// - a 4-bit write-only page latch supplies the upper four bits for a far branch.
// - page load then short branch: flag 1 loads page plus operand, flag 0 adds two.
// - lone short branch with flag 1 swaps low six bits, bumping page on all-ones; else +1.
// - a short call jumps into page zero with bit zero clear and operand in the middle bits.
// - a short call saves the 10-bit return address before jumping.
// - the return store is one level deep; a second call overwrites it.
// - a return reloads the fetch counter from the return store.
// - a 4-bit table index counter can be loaded, read, incremented and decremented.
// - a table look-up addresses 101111 joined with the table index counter (2F0 to 2FF).
// - each instruction cycle is five clock states; decoder inputs act at the last state.
// - reset sets the condition flag to one.
module program_sequencer
(
   input  wire logic                         ref_clk,
   input  wire logic                         sys_rst,
   input  wire logic                         rst_pin_n,
   input  wire seq_pkg::seq_op_t             op_code,
   input  wire logic [5:0]                   op_operand,
   input  wire logic                         page_write,
   input  wire logic [3:0]                   page_data,
   input  wire logic                         flag_write,
   input  wire logic                         flag_data,
   input  wire seq_pkg::idx_op_t             idx_op,
   input  wire logic [3:0]                   idx_data,
   output logic [9:0]                        fetch_address_counter,
   output logic [9:0]                        mem_address,
   output logic                              fetch_strobe,
   output logic [2:0]                        state_num,
   output logic                              condition_flag,
   output logic [3:0]                        table_index_counter,
   output logic [9:0]                        return_address,
   output logic                              in_reset
);
   import seq_pkg::*;

   // ----------------------------------------
   // reset pin synchroniser and length filter
   // ----------------------------------------
   logic       rst_meta_reg;
   logic       rst_sync_reg;
   logic [1:0] rst_cnt_reg;
   logic       hold_reg;
   logic       cycle_end;
   logic       core_rst;

   always_ff @(posedge ref_clk)
   begin
      rst_meta_reg <= rst_pin_n;
      rst_sync_reg <= rst_meta_reg;
   end

   // a pin pulse that spans fewer than three cycle ends is ignored
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || rst_sync_reg)
         rst_cnt_reg <= 2'h0;
      else if (cycle_end && rst_cnt_reg != 2'(RESET_CYCLES))
         rst_cnt_reg <= rst_cnt_reg + 2'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         hold_reg <= 1'b1;
      else if (rst_cnt_reg == 2'(RESET_CYCLES))
         hold_reg <= 1'b1;
      else if (rst_sync_reg)
         hold_reg <= 1'b0;
   end

   // the timer keeps running through a pin reset, only the core is held
   assign core_rst = sys_rst || hold_reg;
   assign in_reset = hold_reg;

   // ----------------------------------------
   // instruction cycle timing
   // ----------------------------------------
   state_timer u_timer
   (
      .ref_clk   (ref_clk),
      .sys_rst   (sys_rst),
      .state_num (state_num),
      .cycle_end (cycle_end)
   );

   // ----------------------------------------
   // address selection
   // ----------------------------------------
   logic [9:0] pc_reg;
   logic [9:0] pc_next;
   logic [9:0] ret_reg;
   logic [3:0] page_reg;
   logic       page_armed_reg;
   logic       flag_reg;
   logic [3:0] idx_reg;
   logic       step;
   logic [9:0] pc_plus1;
   logic [9:0] pc_plus2;
   logic [3:0] upper_plus1;
   logic       low_ones;
   logic [9:0] long_target;
   logic [9:0] near_target;
   logic [9:0] call_target;
   logic [9:0] tbl_address;
   logic       do_call;

   assign step        = cycle_end;
   assign pc_plus1    = pc_reg + 10'h001;
   assign pc_plus2    = pc_reg + 10'h002;
   assign upper_plus1 = pc_reg[9:6] + 4'h1;
   // a short branch from the last word of a page lands in the next page
   assign low_ones    = (pc_reg[5:0] == LOW_ALL_ONES);
   assign long_target = {page_reg, op_operand};
   assign near_target = {(low_ones ? upper_plus1 : pc_reg[9:6]), op_operand};
   // calls reach even addresses of page zero only; operand bit zero is not used
   assign call_target = {4'h0, op_operand[5:1], 1'b0};
   assign tbl_address = {TABLE_UPPER, idx_reg};
   assign do_call     = step && op_code == OP_CALL;

   always_comb
   begin
      case (op_code)
         OP_BRANCH:
            if (page_armed_reg)
               pc_next = flag_reg ? long_target : pc_plus2;
            else
               pc_next = flag_reg ? near_target : pc_plus1;
         OP_CALL:   pc_next = call_target;
         OP_RETURN: pc_next = ret_reg;
         default:   pc_next = pc_plus1;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (core_rst)
         pc_reg <= ADDR_RESET;
      else if (step)
         pc_reg <= pc_next;
   end

   // ----------------------------------------
   // return address store
   // ----------------------------------------
   // single slot; a nested call simply overwrites it
   // the saved value is the word after the call, so a return resumes past it
   always_ff @(posedge ref_clk)
   begin
      if (core_rst)
         ret_reg <= ADDR_RESET;
      else if (do_call)
         ret_reg <= pc_plus1;
   end

   // ----------------------------------------
   // page latch
   // ----------------------------------------
   // page load arms the next short branch as a far branch
   // any other instruction in between disarms it, so a stale page is never used
   always_ff @(posedge ref_clk)
   begin
      if (core_rst)
      begin
         page_reg       <= PAGE_RESET;
         page_armed_reg <= 1'b0;
      end
      else if (step)
      begin
         if (page_write)
            page_reg <= page_data;
         page_armed_reg <= page_write;
      end
   end

   // ----------------------------------------
   // condition flag
   // ----------------------------------------
   // a flag written together with a branch only steers the following branch
   always_ff @(posedge ref_clk)
   begin
      if (core_rst)
         flag_reg <= 1'b1;
      else if (step && flag_write)
         flag_reg <= flag_data;
   end

   // ----------------------------------------
   // table index counter
   // ----------------------------------------
   // wraps in both directions, like any plain 4-bit register
   always_ff @(posedge ref_clk)
   begin
      if (core_rst)
         idx_reg <= IDX_RESET;
      else if (step)
         case (idx_op)
            IDX_LOAD: idx_reg <= idx_data;
            IDX_INC:  idx_reg <= idx_reg + 4'h1;
            IDX_DEC:  idx_reg <= idx_reg - 4'h1;
            default:  idx_reg <= idx_reg;
         endcase
   end

   // ----------------------------------------
   // memory address and outputs
   // ----------------------------------------
   // table data is read in the same cycle, then fetch continues
   assign mem_address           = (op_code == OP_TABLE) ? tbl_address : pc_reg;
   assign fetch_address_counter = pc_reg;
   assign fetch_strobe          = step && !core_rst;
   assign condition_flag        = flag_reg;
   assign table_index_counter   = idx_reg;
   assign return_address        = ret_reg;
endmodule : program_sequencer
`default_nettype wire

/* hdl/seq_pkg.sv */
package seq_pkg;
   localparam int          ADDR_W        = 10;
   localparam int          PAGE_W        = 4;
   localparam int          LOW_W         = 6;
   localparam int          IDX_W         = 4;
   localparam int          STATES        = 5;
   localparam logic [9:0]  ADDR_RESET    = 10'h000;
   localparam logic [3:0]  PAGE_RESET    = 4'h0;
   localparam logic [3:0]  IDX_RESET     = 4'h0;
   localparam logic [5:0]  TABLE_UPPER   = 6'h2F;
   localparam logic [5:0]  LOW_ALL_ONES  = 6'h3F;
   localparam logic [2:0]  STATE_LAST    = 3'h4;
   localparam logic [2:0]  FETCH_STATE   = 3'h4;
   localparam int          RESET_CYCLES  = 3;

   typedef enum logic [2:0]
   {
      OP_NONE   = 3'b000,
      OP_BRANCH = 3'b001,
      OP_CALL   = 3'b010,
      OP_RETURN = 3'b011,
      OP_TABLE  = 3'b100
   } seq_op_t;

   typedef enum logic [1:0]
   {
      IDX_HOLD = 2'b00,
      IDX_LOAD = 2'b01,
      IDX_INC  = 2'b10,
      IDX_DEC  = 2'b11
   } idx_op_t;
endpackage : seq_pkg

/* hdl/state_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// five-state instruction cycle timer
// ----------------------------------------
module state_timer
(
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   output logic [2:0]      state_num,
   output logic            cycle_end
);
   import seq_pkg::*;

   logic [2:0] state_reg;
   logic [2:0] state_next;

   assign state_next = (state_reg == STATE_LAST) ? 3'h0 : state_reg + 3'h1;
   assign state_num  = state_reg;
   assign cycle_end  = (state_reg == STATE_LAST);

   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         state_reg <= 3'h0;
      else
         state_reg <= state_next;
   end
endmodule : state_timer
`default_nettype wire

/* bench/rom_model.sv */
`timescale 1ns/100ps
`default_nettype none
// nothing is fitted above 2ff: reads there return the idle opcode
module rom_model
(
   input  wire logic [9:0] mem_address,
   output logic      [7:0] rom_data
);
   assign rom_data = (mem_address >= 10'h300) ? 8'h7f : mem_address[7:0];
endmodule : rom_model
`default_nettype wire

/* bench/seq_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module seq_monitor
(
   input wire logic             ref_clk,
   input wire logic             sys_rst,
   input wire seq_pkg::seq_op_t op_code,
   input wire logic [3:0]       page_data,
   input wire logic [5:0]       op_operand,
   input wire logic             page_write,
   input wire seq_pkg::idx_op_t idx_op,
   input wire logic [9:0]       fetch_address_counter,
   input wire logic [9:0]       mem_address,
   input wire logic             fetch_strobe,
   input wire logic [2:0]       state_num,
   input wire logic             condition_flag,
   input wire logic [3:0]       table_index_counter,
   input wire logic [9:0]       return_address,
   input wire logic             in_reset
);
   import seq_pkg::*;
   logic       arm_reg;
   wire        take = fetch_strobe && !in_reset;
   wire  [9:0] pc   = fetch_address_counter;
   // a page load arms only the very next instruction
   always_ff @(posedge ref_clk) arm_reg <= (sys_rst || in_reset) ? 1'b0 : (take ? page_write : arm_reg);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_take(seq_op_t o); take && op_code == o; endsequence
   a_plain_step: assert property (s_take(OP_NONE) |=> pc == $past(pc) + 10'h001)
      else $error("counter did not step by one");
   a_lone_branch: assert property (s_take(OP_BRANCH) ##0 (!arm_reg && condition_flag)
      |=> pc[5:0] == $past(op_operand)) else $error("short branch target wrong");
   a_call_target: assert property (s_take(OP_CALL)
      |=> pc == {4'b0000, $past(op_operand[5:1]), 1'b0})
      else $error("call target wrong");
   a_call_saves: assert property (s_take(OP_CALL) |=> return_address == $past(pc) + 10'h001)
      else $error("return address not saved");
   a_return_load: assert property (s_take(OP_RETURN) |=> pc == $past(return_address))
      else $error("return did not reload");
   a_table_addr: assert property (op_code == OP_TABLE |->
      mem_address == {TABLE_UPPER, table_index_counter}) else $error("table address wrong");
   a_reset_clear: assert property ($fell(sys_rst) |-> pc == 10'h000 && condition_flag)
      else $error("reset values wrong");
   a_state_wrap: assert property (fetch_strobe |-> state_num == STATE_LAST ##1 state_num == 0)
      else $error("state sequence wrong");
   a_index_step: assert property (take && idx_op == IDX_INC |=>
      table_index_counter == $past(table_index_counter) + 4'h1) else $error("index not bumped");
   // a page load followed by a branch in the very next instruction cycle
   sequence s_far_branch;
      take && page_write ##5 s_take(OP_BRANCH);
   endsequence
   a_far_taken: assert property (s_far_branch ##0 condition_flag
      |=> pc == {$past(page_data, 6), $past(op_operand)})
      else $error("far branch target wrong");
   a_far_skip: assert property (s_far_branch ##0 !condition_flag
      |=> pc == $past(pc) + 10'h002) else $error("far branch skip wrong");
endmodule : seq_monitor
`default_nettype wire

/* bench/program_sequencer_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module program_sequencer_bench;
   import seq_pkg::*;
   logic ref_clk = 0, sys_rst = 1, rst_pin_n = 1, pw = 0, fw = 0, fd = 0;
   logic [3:0] pd = 0, idd = 0, idx;
   logic [7:0] rd;
   logic [5:0] opd = 0;
   seq_op_t op = OP_NONE;
   idx_op_t iop = IDX_HOLD;
   logic [9:0] pc, ma, ret;
   logic [2:0] st;
   logic fs, flg, inr;
   int error_cnt = 0, n_checks = 0, m_pc, m_ret, m_idx, m_flg, m_pg, m_arm;
   program_sequencer u_program_sequencer (.ref_clk, .sys_rst, .rst_pin_n, .op_code(op),
      .op_operand(opd), .page_write(pw), .page_data(pd), .flag_write(fw),
      .flag_data(fd), .idx_op(iop), .idx_data(idd), .fetch_address_counter(pc),
      .mem_address(ma), .fetch_strobe(fs), .state_num(st), .condition_flag(flg),
      .table_index_counter(idx), .return_address(ret), .in_reset(inr));
   rom_model u_rom_model (.mem_address(ma), .rom_data(rd));
   initial forever #4 ref_clk = ~ref_clk;
   task chk(string n, int e, logic [9:0] g);
      n_checks++;
      if (g !== 10'(e))
      begin
         error_cnt++;
         $display("FAIL %s exp %0h got %0h", n, 10'(e), g);
      end
   endtask : chk
   task step(seq_op_t o, logic w, logic f, idx_op_t i);
      repeat (8) if (st !== STATE_LAST) @(negedge ref_clk);
      op = o;
      pw = w;
      fw = f;
      iop = i;
      opd = 6'($urandom);
      pd = 4'($urandom);
      fd = 1'($urandom);
      idd = 4'($urandom);
      #1;
      if (o == OP_TABLE) chk("table", 'h2f0 + m_idx, ma);
      if (o == OP_TABLE) chk("table data", 'hf0 + m_idx, 10'(rd));
      if (o == OP_CALL) m_ret = (m_pc + 1) % 1024;
      case (o)
         OP_BRANCH: m_pc = m_arm ? (m_flg ? m_pg * 64 + opd : m_pc + 2)
            : (m_flg ? (m_pc / 64 + (m_pc % 64 == 63)) * 64 + opd : m_pc + 1);
         OP_CALL: m_pc = opd[5:1] * 2;
         OP_RETURN: m_pc = m_ret;
         default: m_pc = m_pc + 1;
      endcase
      m_pc = m_pc % 1024;
      m_arm = w;
      m_pg = w ? pd : m_pg;
      m_flg = f ? fd : m_flg;
      m_idx = (i == IDX_LOAD) ? idd : (i == IDX_INC) ? m_idx + 1 : (i == IDX_DEC) ? m_idx + 15 : m_idx;
      m_idx = m_idx % 16;
      @(negedge ref_clk);
      op = OP_NONE;
      pw = 1'b0;
      fw = 1'b0;
      iop = IDX_HOLD;
      chk("pc", m_pc, pc);
      chk("ret", m_ret, ret);
      chk("idx", m_idx, 10'(idx));
      chk("flag", m_flg, 10'(flg));
   endtask : step
   task do_reset(bit pin);
      rst_pin_n = !pin;
      sys_rst = !pin;
      repeat (pin ? 30 : 3) @(negedge ref_clk);
      rst_pin_n = 1'b1;
      sys_rst = 1'b0;
      m_pc = 0;
      m_flg = 1;
      m_arm = 0;
      m_pg = 0;
      m_ret = 0;
      m_idx = 0;
      repeat (40) if (inr !== 1'b0) @(negedge ref_clk);
      chk("pc", 0, pc);
      chk("flag", 1, 10'(flg));
      step(OP_CALL, 0, 0, IDX_LOAD);
   endtask : do_reset
   task run(int n);
      seq_op_t o;
      repeat (n)
      begin
         o = (m_arm && $urandom_range(1)) ? OP_BRANCH : seq_op_t'($urandom_range(4));
         step(o, o == OP_NONE && $urandom_range(3) == 0, o != OP_BRANCH && $urandom_range(3) == 0,
            idx_op_t'($urandom_range(3)));
      end
   endtask : run
   task end_of_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test
   initial
   begin
      void'($urandom(84));
      do_reset(0);
      run(500);
      do_reset(0);
      run(100);
      do_reset(1);
      run(100);
      end_of_test;
   end
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      end_of_test;
   end
endmodule : program_sequencer_bench
bind program_sequencer seq_monitor u_seq_monitor (.ref_clk, .sys_rst, .op_code, .page_data,
   .op_operand, .page_write, .idx_op, .fetch_address_counter, .mem_address, .fetch_strobe,
   .state_num, .condition_flag, .table_index_counter, .return_address, .in_reset);
`default_nettype wire
